/* inc/ifw_defs.svh */
/*
  register offsets, field positions, reset values and sizes for the
  interrupt flag and wakeup control block.
  assumes an 8-bit register port with byte offsets.
*/
`ifndef IFW_DEFS_SVH
`define IFW_DEFS_SVH

`define IFW_ADDR_W        8
`define IFW_OFS_EDGE_SEL  8'h00_F2
`define IFW_OFS_IEN_ONE   8'h00_F3
`define IFW_OFS_IEN_TWO   8'h00_F4
`define IFW_OFS_IRR_ONE   8'h00_F6
`define IFW_OFS_IRR_TWO   8'h00_F7
`define IFW_OFS_WKUP_FLG  8'h00_F9
`define IFW_OFS_CKSTP_ONE 8'h00_FA
`define IFW_OFS_CKSTP_TWO 8'h00_FB

`define IFW_RST_ZERO      8'h00_00
`define IFW_RST_CKSTP     8'h00_FF

// one request register: bit 7 timer a, 6 serial 1, 5 wakeup, 4..0 ext
`define IFW_BIT_TIMER_A   7
`define IFW_BIT_SERIAL1   6
`define IFW_BIT_WAKEUP    5
`define IFW_BIT_EXT4      4
// writable-to-clear masks
`define IFW_CLR_MASK_ONE  8'h00_DF
`define IFW_CLR_MASK_TWO  8'h00_DE
// request register two: bit 7 direct transition
`define IFW_BIT_DIRECT    7
`define IFW_BIT_EDGE4     4
`define IFW_BIT_CK_SERIAL_CHANNEL_ONE   6
`define IFW_BIT_CK_WDT    2

`endif

/* inc/ifw_pkg.sv */
/*
  types shared by the interrupt flag and wakeup control block.
  assumes nothing beyond the defs header.
*/
package ifw_pkg;
  typedef logic [7:0] ifw_byte_t;
endpackage

/* verilog/ifw_ctrl.sv */
/*
  interrupt enables, request flags, wakeup flags, edge select and
  module standby controls of a small controller.
  assumes pins arrive asynchronous, peripheral events are one-cycle
  pulses on clk, and the cpu uses the plain strobe register port.
*/
// Implementation choice: strobed register access.
// Behaviour
// RULE1 - external irq four and the conversion trigger detect falling edges when edge select is 0 and rising edges when it is 1.
// RULE2 - enable register one holds eight read/write bits cleared by reset: timer a, serial 1, wakeup, ext 4..0.
// RULE3 - the direct transition enable blocks direct transition requests at 0 and passes them at 1.
// RULE4 - the timer a request flag sets when the timer a counter overflows from all ones to zero.
// RULE5 - software clears the timer a flag by writing 0 while it reads 1.
// RULE6 - request register one bits 7, 6 and 4..0 take only 0 writes, which clear; 1 writes do nothing.
// RULE7 - request register two bits 7, 6 and 4..1 take only 0 writes, which clear; 1 writes do nothing.
// RULE8 - wakeup flag n sets on either edge of wakeup pin n when that pin is configured as wakeup input.
// RULE9 - all eight wakeup flags clear by 0 writes only and are 0 after reset.
// RULE10 - serial channel one is in module standby while its clock stop bit is 0.
// RULE11 - the watchdog unit is in module standby while its clock stop bit is 0.
// RULE12 - a source requests the cpu only while its flag and its enable are both 1.
`timescale 1ns/1ps
`include "ifw_defs.svh"

module ifw_ctrl
  import ifw_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // register port
  input  wire logic [`IFW_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  // asynchronous pins
  input  wire logic [4:0]             ext_irq_pin,
  input  wire logic                   conversion_trigger_pin,
  input  wire logic [7:0]             wakeup_pin_n,
  input  wire logic [7:0]             wakeup_pin_sel,
  // on-chip event pulses
  input  wire logic                   timer_a_overflow,
  input  wire logic                   serial1_event,
  input  wire logic [7:0]             irr_two_event,
  // outputs
  output logic                        conv_trigger_det,
  output logic      [7:0]             irq_one_req,
  output logic      [7:0]             irq_two_req,
  output logic                        irq_out,
  output logic                        serial_channel_one_stby,
  output logic                        watchdog_unit_stby
);

  ifw_byte_t edge_sel_r, ien_one_r, ien_two_r;
  ifw_byte_t irr_one_r, irr_one_nxt, irr_two_r, irr_two_nxt;
  ifw_byte_t wkup_r, wkup_nxt, ckstp_one_r, ckstp_two_r;
  ifw_byte_t rdata_r;
  logic [4:0] ext_s1_r, ext_s2_r, ext_d_r;
  logic       adt_s1_r, adt_s2_r, adt_d_r;
  logic [7:0] wk_s1_r, wk_s2_r, wk_d_r;

  // pin synchronisers plus one delay stage for edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_s1_r <= 5'h1F;
      ext_s2_r <= 5'h1F;
      ext_d_r  <= 5'h1F;
      adt_s1_r <= 1'b1;
      adt_s2_r <= 1'b1;
      adt_d_r  <= 1'b1;
      wk_s1_r  <= 8'h00_00;
      wk_s2_r  <= 8'h00_00;
      wk_d_r   <= 8'h00_00;
    end else begin
      ext_s1_r <= ext_irq_pin;
      ext_s2_r <= ext_s1_r;
      ext_d_r  <= ext_s2_r;
      adt_s1_r <= conversion_trigger_pin;
      adt_s2_r <= adt_s1_r;
      adt_d_r  <= adt_s2_r;
      wk_s1_r  <= wakeup_pin_n;
      wk_s2_r  <= wk_s1_r;
      wk_d_r   <= wk_s2_r;
    end
  end

  // address decode
  wire sel_edge  = reg_addr == `IFW_OFS_EDGE_SEL;
  wire sel_ien1  = reg_addr == `IFW_OFS_IEN_ONE;
  wire sel_ien2  = reg_addr == `IFW_OFS_IEN_TWO;
  wire sel_request_flags_one  = reg_addr == `IFW_OFS_IRR_ONE;
  wire sel_request_flags_two  = reg_addr == `IFW_OFS_IRR_TWO;
  wire sel_wkup  = reg_addr == `IFW_OFS_WKUP_FLG;
  wire sel_ck1   = reg_addr == `IFW_OFS_CKSTP_ONE;
  wire sel_ck2   = reg_addr == `IFW_OFS_CKSTP_TWO;

  // edge events; irq 3..0 take falling edges, irq four selectable
  wire rise4 = edge_sel_r[`IFW_BIT_EDGE4];
  wire [4:0] ext_fall = ext_d_r & ~ext_s2_r;
  wire [4:0] ext_rise = ~ext_d_r & ext_s2_r;
  wire ext4_ev = rise4 ? ext_rise[4] : ext_fall[4]; // see RULE1
  wire adt_ev  = rise4 ? (~adt_d_r & adt_s2_r)
                       : (adt_d_r & ~adt_s2_r); // see RULE1
  wire [7:0] wk_ev = (wk_d_r ^ wk_s2_r) & wakeup_pin_sel; // see RULE8

  // set terms, one per bit of request register one
  wire [7:0] request_flags_one_set = {timer_a_overflow, serial1_event, |wkup_r,
                         ext4_ev, ext_fall[3:0]};

  // clear by 0 write on writable bits; set wins over clear
  wire [7:0] clr1 = (reg_wr && sel_request_flags_one) ?
                    (~reg_wdata & `IFW_CLR_MASK_ONE) : 8'h00_00;
  wire [7:0] clr2 = (reg_wr && sel_request_flags_two) ?
                    (~reg_wdata & `IFW_CLR_MASK_TWO) : 8'h00_00;
  wire [7:0] clrw = (reg_wr && sel_wkup) ? ~reg_wdata : 8'h00_00;

  // bit 5 mirrors the wakeup flags, so it is not a stored flag
  assign irr_one_nxt = ((irr_one_r & ~clr1) | request_flags_one_set)
                       & `IFW_CLR_MASK_ONE; // see RULE4, RULE5, RULE6
  assign irr_two_nxt = ((irr_two_r & ~clr2) | irr_two_event)
                       & `IFW_CLR_MASK_TWO; // see RULE7
  assign wkup_nxt    = (wkup_r & ~clrw) | wk_ev; // see RULE8, RULE9

  wire ifw_byte_t irr_one_view = irr_one_r |
                   ({7'h00, |wkup_r} << `IFW_BIT_WAKEUP);

  // read mux
  wire ifw_byte_t rd_mux =
      sel_edge ? edge_sel_r   :
      sel_ien1 ? ien_one_r    :
      sel_ien2 ? ien_two_r    :
      sel_request_flags_one ? irr_one_view :
      sel_request_flags_two ? irr_two_r    :
      sel_wkup ? wkup_r       :
      sel_ck1  ? ckstp_one_r  :
      sel_ck2  ? ckstp_two_r  : 8'h00_00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_sel_r  <= `IFW_RST_ZERO;
      ien_one_r   <= `IFW_RST_ZERO;
      ien_two_r   <= `IFW_RST_ZERO;
      ckstp_one_r <= `IFW_RST_CKSTP;
      ckstp_two_r <= `IFW_RST_CKSTP;
    end else if (reg_wr) begin
      if (sel_edge) edge_sel_r  <= reg_wdata; // see RULE1
      if (sel_ien1) ien_one_r   <= reg_wdata; // see RULE2
      if (sel_ien2) ien_two_r   <= reg_wdata; // see RULE3
      if (sel_ck1)  ckstp_one_r <= reg_wdata; // see RULE10
      if (sel_ck2)  ckstp_two_r <= reg_wdata; // see RULE11
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irr_one_r <= `IFW_RST_ZERO;
      irr_two_r <= `IFW_RST_ZERO;
      wkup_r    <= `IFW_RST_ZERO; // see RULE9
      rdata_r   <= `IFW_RST_ZERO;
    end else begin
      irr_one_r <= irr_one_nxt;
      irr_two_r <= irr_two_nxt;
      wkup_r    <= wkup_nxt;
      rdata_r   <= reg_rd ? rd_mux : `IFW_RST_ZERO;
    end
  end

  // outputs; only bits with both flag and enable go to the cpu
  assign reg_rdata   = rdata_r;
  assign irq_one_req = irr_one_view & ien_one_r; // see RULE12, RULE2
  assign irq_two_req = irr_two_r & ien_two_r; // see RULE3, RULE12
  assign irq_out     = |irq_one_req | |irq_two_req;
  assign conv_trigger_det = adt_ev; // see RULE1
  assign serial_channel_one_stby =
      ~ckstp_one_r[`IFW_BIT_CK_SERIAL_CHANNEL_ONE]; // see RULE10
  assign watchdog_unit_stby = ~ckstp_two_r[`IFW_BIT_CK_WDT]; // see RULE11

  // checks
  a_timer_set: assert property (@(posedge clk) disable iff (!rst_b)
    timer_a_overflow |=> irr_one_r[`IFW_BIT_TIMER_A]) // see RULE4
    else $error("timer a flag not set after overflow");
  a_timer_clear: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && sel_request_flags_one && !reg_wdata[`IFW_BIT_TIMER_A]
      && !timer_a_overflow |=> !irr_one_r[`IFW_BIT_TIMER_A]) // see RULE5
    else $error("timer a flag not cleared by zero write");
  a_one_write_hold: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && sel_request_flags_one && reg_wdata == 8'hFF
      |=> irr_one_r[4:0] == ($past(irr_one_r[4:0]) | $past(request_flags_one_set[4:0])))
    // see RULE6
    else $error("one write changed request flags");
  a_two_write_hold: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && sel_request_flags_two && reg_wdata == 8'hFF && irr_two_event == 8'h00
      |=> irr_two_r == $past(irr_two_r)) // see RULE7
    else $error("one write changed request register two");
  a_wakeup_set: assert property (@(posedge clk) disable iff (!rst_b)
    (wk_d_r[0] != wk_s2_r[0]) && wakeup_pin_sel[0] |=> wkup_r[0])
    // see RULE8
    else $error("wakeup flag missed an edge");
  a_wakeup_clear: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && sel_wkup && reg_wdata == 8'h00 && wk_ev == 8'h00
      |=> wkup_r == 8'h00) // see RULE9
    else $error("wakeup flags not cleared");
  a_sci_stby: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && sel_ck1 |=> serial_channel_one_stby ==
      !$past(reg_wdata[`IFW_BIT_CK_SERIAL_CHANNEL_ONE])) // see RULE10
    else $error("serial standby wrong");
  a_wdt_stby: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && sel_ck2 |=> watchdog_unit_stby ==
      !$past(reg_wdata[`IFW_BIT_CK_WDT])) // see RULE11
    else $error("watchdog standby wrong");
  a_direct_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !ien_two_r[`IFW_BIT_DIRECT] |-> !irq_two_req[`IFW_BIT_DIRECT])
    // see RULE3
    else $error("direct request passed while disabled");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
    irq_out |-> ((irr_one_view & ien_one_r) != 8'h00)
      || ((irr_two_r & ien_two_r) != 8'h00)) // see RULE12
    else $error("interrupt without enabled flag");

  a_timer_hold: assert property ( // see RULE5
    @(posedge clk) disable iff (!rst_b)
    reg_wr && sel_request_flags_one && reg_wdata[7] && irr_one_r[7] |=> irr_one_r[7])
    else $error("timer a flag lost on a one write");

  a_serial_set: assert property ( // see RULE6
    @(posedge clk) disable iff (!rst_b)
    serial1_event |=> irr_one_r[`IFW_BIT_SERIAL1])
    else $error("serial flag not set after event");

  a_one_zero_clear: assert property ( // see RULE6
    @(posedge clk) disable iff (!rst_b)
    reg_wr && sel_request_flags_one && reg_wdata == 8'h00 && request_flags_one_set == 8'h00
      |=> irr_one_r == 8'h00)
    else $error("zero write left request flags set");

  a_two_zero_clear: assert property ( // see RULE7
    @(posedge clk) disable iff (!rst_b)
    reg_wr && sel_request_flags_two && reg_wdata == 8'h00 && irr_two_event == 8'h00
      |=> irr_two_r == 8'h00)
    else $error("zero write left register two flags set");

  a_two_fixed_bits: assert property ( // see RULE7
    @(posedge clk) disable iff (!rst_b)
    (irr_two_r & ~`IFW_CLR_MASK_TWO) == 8'h00)
    else $error("unused register two bit set");

  a_two_set: assert property ( // see RULE7
    @(posedge clk) disable iff (!rst_b)
    irr_two_event[`IFW_BIT_DIRECT] |=> irr_two_r[`IFW_BIT_DIRECT])
    else $error("direct flag not set after event");

  a_sci_hold: assert property ( // see RULE10
    @(posedge clk) disable iff (!rst_b)
    !(reg_wr && sel_ck1) |=> $stable(serial_channel_one_stby))
    else $error("serial standby moved without a write");

  a_wdt_hold: assert property ( // see RULE11
    @(posedge clk) disable iff (!rst_b)
    !(reg_wr && sel_ck2) |=> $stable(watchdog_unit_stby))
    else $error("watchdog standby moved without a write");

  a_direct_pass: assert property ( // see RULE3
    @(posedge clk) disable iff (!rst_b)
    ien_two_r[`IFW_BIT_DIRECT] && irr_two_r[`IFW_BIT_DIRECT]
      |-> irq_two_req[`IFW_BIT_DIRECT])
    else $error("direct request blocked while enabled");

  a_irq_all_off: assert property ( // see RULE12
    @(posedge clk) disable iff (!rst_b)
    ien_one_r == 8'h00 && ien_two_r == 8'h00 |-> !irq_out)
    else $error("interrupt with every enable clear");

  a_ien1_write: assert property ( // see RULE2
    @(posedge clk) disable iff (!rst_b)
    reg_wr && sel_ien1 |=> ien_one_r == $past(reg_wdata))
    else $error("enable one write lost");

  a_ien1_hold: assert property ( // see RULE2
    @(posedge clk) disable iff (!rst_b)
    !(reg_wr && sel_ien1) |=> $stable(ien_one_r))
    else $error("enable one changed without a write");

  a_ien2_write: assert property ( // see RULE3
    @(posedge clk) disable iff (!rst_b)
    reg_wr && sel_ien2 |=> ien_two_r == $past(reg_wdata))
    else $error("enable two write lost");

  a_edge_write: assert property ( // see RULE1
    @(posedge clk) disable iff (!rst_b)
    reg_wr && sel_edge |=> edge_sel_r == $past(reg_wdata))
    else $error("edge select write lost");

  a_fall_detect: assert property ( // see RULE1
    @(posedge clk) disable iff (!rst_b)
    !edge_sel_r[`IFW_BIT_EDGE4] && adt_d_r && !adt_s2_r
      |-> conv_trigger_det)
    else $error("falling trigger edge missed");

  a_rise_detect: assert property ( // see RULE1
    @(posedge clk) disable iff (!rst_b)
    edge_sel_r[`IFW_BIT_EDGE4] && !adt_d_r && adt_s2_r
      |-> conv_trigger_det)
    else $error("rising trigger edge missed");

  a_wrong_edge: assert property ( // see RULE1
    @(posedge clk) disable iff (!rst_b)
    !edge_sel_r[`IFW_BIT_EDGE4] && !adt_d_r && adt_s2_r
      |-> !conv_trigger_det)
    else $error("trigger fired on the wrong edge");

  a_ext4_flag: assert property ( // see RULE1
    @(posedge clk) disable iff (!rst_b)
    ext4_ev |=> irr_one_r[`IFW_BIT_EXT4])
    else $error("irq four flag not set after edge");

  a_ext0_flag: assert property ( // see RULE6
    @(posedge clk) disable iff (!rst_b)
    ext_fall[0] |=> irr_one_r[0])
    else $error("irq zero flag not set after edge");

  a_rdata_idle: assert property (
    @(posedge clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside a read cycle");

  a_rdata_request_flags_one: assert property ( // see RULE6
    @(posedge clk) disable iff (!rst_b)
    reg_rd && sel_request_flags_one |=> reg_rdata == $past(irr_one_view))
    else $error("request one read data wrong");

  // per-bit wakeup flag checks
  for (genvar gi = 0; gi < 8; gi++) begin : g_wk_chk
    a_wk_set: assert property ( // see RULE8
      @(posedge clk) disable iff (!rst_b)
      wk_ev[gi] |=> wkup_r[gi])
      else $error("wakeup flag missed its edge");
    a_wk_no_spurious: assert property ( // see RULE8
      @(posedge clk) disable iff (!rst_b)
      !wkup_r[gi] && !wk_ev[gi] |=> !wkup_r[gi])
      else $error("wakeup flag set without an edge");
    a_wk_sticky: assert property ( // see RULE9
      @(posedge clk) disable iff (!rst_b)
      wkup_r[gi] && !(reg_wr && sel_wkup && !reg_wdata[gi])
        |=> wkup_r[gi])
      else $error("wakeup flag lost without a zero write");
    a_wk_clear: assert property ( // see RULE9
      @(posedge clk) disable iff (!rst_b)
      reg_wr && sel_wkup && !reg_wdata[gi] && !wk_ev[gi] |=> !wkup_r[gi])
      else $error("wakeup flag kept after a zero write");
  end

endmodule // ifw_ctrl

/* verification/ifw_cpu_model.sv */
/*
  cpu model: master of the plain register port.
  assumes one clk and a slave that never makes it wait.
*/
`timescale 1ns/1ps
module ifw_cpu_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00_00;
    reg_wdata = 8'h00_00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // ones elsewhere, so untouched flags survive
  task automatic clr_flag(input logic [7:0] a, input logic [7:0] m);
    wr_reg(a, ~m);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // ifw_cpu_model

/* verification/test_ifw_ctrl.sv */
/*
  self-checking bench of the flag and wakeup block.
  assumes the cpu model drives the register port.
*/
`timescale 1ns/1ps
module test_ifw_ctrl;
  import ifw_pkg::*;
  logic clk, rst_b, conv_pin, conv_det, irq_out, s_stby, w_stby;
  logic [1:0] ev;
  logic [4:0] ext_pin;
  logic [7:0] a, wd, rdat, wk_pin, wk_sel, ev2, req1, req2, r, x;
  logic wr, rd;
  int miscompares, total_checks, conv_cnt, n;
  logic [7:0] ra [5] = '{8'h00_F3, 8'h00_F9, 8'h00_F6, 8'h00_FA, 8'h00_FB};
  logic [7:0] re [5] = '{8'h00_00, 8'h00_00, 8'h00_00, 8'h00_FF, 8'h00_FF};
  ifw_cpu_model cpu (.clk(clk), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdat));
  ifw_ctrl dut (.clk(clk), .rst_b(rst_b), .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .ext_irq_pin(ext_pin),
    .conversion_trigger_pin(conv_pin), .wakeup_pin_n(wk_pin),
    .wakeup_pin_sel(wk_sel), .timer_a_overflow(ev[1]),
    .serial1_event(ev[0]), .irr_two_event(ev2),
    .conv_trigger_det(conv_det), .irq_one_req(req1), .irq_two_req(req2),
    .irq_out(irq_out), .serial_channel_one_stby(s_stby),
    .watchdog_unit_stby(w_stby));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (conv_det === 1'b1) conv_cnt++;
  task automatic check(input string nm, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2_000_000 miscompares++;
    results();
  end
  initial begin
    rst_b = 1'b0; ev = 2'b00; ev2 = 8'h00_00; ext_pin = 5'h1F; conv_pin = 1'b1;
    wk_pin = 8'h00_00; wk_sel = 8'h00_00; conv_cnt = 0;
    n = $urandom(32'h0b29);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      cpu.rd_reg(ra[i], r);
      check("reset value", r, re[i]);
    end
    check("standby", {s_stby, w_stby}, 8'h00_00);
    x = $urandom;
    cpu.wr_reg(8'h00_F3, x);
    cpu.rd_reg(8'h00_F3, r);
    check("enable one", r, x);
    for (int i = 0; i < 2; i++) begin
      x = 8'h00_80 >> i;
      cpu.wr_reg(8'h00_F3, 8'h00_00);
      @(posedge clk) ev <= 2'b10 >> i;
      @(posedge clk) ev <= 2'b00;
      cpu.wr_reg(8'h00_F6, 8'h00_FF);
      cpu.rd_reg(8'h00_F6, r);
      check("request one", r, x);
      check("masked request", req1, 8'h00_00);
      cpu.wr_reg(8'h00_F3, x);
      check("request out", req1 & {8{irq_out}}, x);
      cpu.clr_flag(8'h00_F6, x);
      cpu.rd_reg(8'h00_F6, r);
      check("cleared one", r | {7'h00, irq_out}, 8'h00);
    end
    // pin four and the trigger share the edge select bit
    for (int e = 0; e < 2; e++) begin
      cpu.wr_reg(8'h00_F2, 8'(e << 4));
      cpu.clr_flag(8'h00_F6, 8'h00_1F);
      ext_pin[4] <= e[0];
      conv_pin <= e[0];
      repeat (4) @(posedge clk);
      cpu.rd_reg(8'h00_F6, r);
      check("edge flag", r, 8'h00_10);
    end
    cpu.clr_flag(8'h00_F6, 8'h00_1F);
    ext_pin[4] <= 1'b0;
    conv_pin <= 1'b0;
    repeat (4) @(posedge clk);
    cpu.rd_reg(8'h00_F6, r);
    check("wrong edge", r, 8'h00_00);
    check("trigger count", 8'(conv_cnt), 8'h00_02);
    n = $urandom_range(7, 0);
    x = 8'h00_01 << n;
    wk_sel <= x;
    wk_pin <= ~wk_pin;
    repeat (4) @(posedge clk);
    cpu.wr_reg(8'h00_F9, 8'h00_FF);
    cpu.rd_reg(8'h00_F9, r);
    check("wakeup flags", r, x);
    cpu.rd_reg(8'h00_F6, r);
    check("wakeup summary", r, 8'h00_20);
    cpu.clr_flag(8'h00_F9, x);
    cpu.rd_reg(8'h00_F9, r);
    check("wakeup cleared", r, 8'h00_00);
    @(posedge clk) ev2 <= 8'h00_81;
    @(posedge clk) ev2 <= 8'h00_00;
    cpu.wr_reg(8'h00_F4, 8'h00_00);
    check("direct blocked", req2, 8'h00_00);
    cpu.wr_reg(8'h00_F4, 8'h00_80);
    check("direct passed", req2, 8'h00_80);
    cpu.wr_reg(8'h00_F7, 8'h00_FF);
    cpu.rd_reg(8'h00_F7, r);
    check("request two", r, 8'h00_80);
    cpu.clr_flag(8'h00_F7, 8'h00_80);
    cpu.rd_reg(8'h00_F7, r);
    check("cleared two", r, 8'h00_00);
    cpu.wr_reg(8'h00_FA, 8'h00_BF);
    cpu.wr_reg(8'h00_FB, 8'h00_FB);
    check("standby on", {s_stby, w_stby}, 8'h00_03);
    cpu.wr_reg(8'h00_FA, 8'h00_FF);
    cpu.wr_reg(8'h00_FB, 8'h00_FF);
    check("standby off", {s_stby, w_stby}, 8'h00_00);
    cpu.rd_reg(8'h00_F0, r);
    check("unmapped", r, 8'h00_00);
    results();
  end
endmodule // test_ifw_ctrl
